// [logic/ewp_decision.sv]
`timescale 1ns/100ps
`default_nettype none
`include "ewp_decision_defs.svh"

module ewp_decision #(
	parameter int ADDR_WIDTH = 8
) (
	input  wire logic                  clk,
	input  wire logic                  resetn,
	input  wire ewp_pkg::ewp_pins_t    pins,
	input  wire logic                  addrByteValid,
	input  wire logic [7:0]            addrByte,
	input  wire logic                  dataByteValid,
	input  wire logic [ADDR_WIDTH-1:0] dataAddr,
	input  wire logic                  writeStop,
	input  wire ewp_pkg::ewp_flags_t   nvFlagsIn,
	output var  logic                  sdaOut,
	output var  logic                  sdaOe,
	output var  logic                  ackGiven,
	output var  logic                  arrayReadEn,
	output var  logic                  arrayStore,
	output var  logic [ADDR_WIDTH-1:0] arrayStoreAddr,
	output var  ewp_pkg::ewp_flags_t   flags,
	output var  logic                  nvFlagsUpdate
);

	// Elaboration check: decode and store gating assume a 256-word array
	if (ADDR_WIDTH != 8)
	begin : g_width_check
		$error("ewp_decision: ADDR_WIDTH must be 8 for a 256-word array");
	end

	// ========================================
	// Pin synchronisers
	// ========================================
	ewp_pkg::ewp_pins_t pinsSync;
	logic               serialClkPrev_q;
	logic               serialClkFall;
	logic               protectHigh;

	ewp_sync3 #(
		.WIDTH ($bits(ewp_pkg::ewp_pins_t))
	) u_sync (
		.clk    (clk),
		.resetn (resetn),
		.async  (pins),
		.synced (pinsSync)
	);

	always_ff @(posedge clk)
	begin
		if (!resetn)
			serialClkPrev_q <= `EWP_SYNC_RESET;
		else
			serialClkPrev_q <= pinsSync.serialClk;
	end

	assign serialClkFall = serialClkPrev_q & ~pinsSync.serialClk;
	// A floating pin is pulled to ground by the pad, so it reads as low
	assign protectHigh = pinsSync.protectPin;

	// ========================================
	// Command decode
	// ========================================
	ewp_pkg::ewp_cmd_t cmd;
	logic [3:0]        preamble;
	logic [2:0]        subCode;
	logic              isRead;

	assign preamble = addrByte[`EWP_PREAMBLE_MSB:`EWP_PREAMBLE_LSB];
	assign subCode  = addrByte[`EWP_SUBCODE_MSB:`EWP_SUBCODE_LSB];
	assign isRead   = addrByte[`EWP_RW_BIT];

	always_comb
	begin
		cmd = ewp_pkg::EWP_CMD_NONE;
		if (preamble == `EWP_PREAMBLE_ARRAY)
			cmd = isRead ? ewp_pkg::EWP_CMD_ARRAY_RD : ewp_pkg::EWP_CMD_ARRAY_WR;
		else if (preamble == `EWP_PREAMBLE_FLAG)
		begin
			if (!pinsSync.elevatedPinLevel)
				cmd = isRead ? ewp_pkg::EWP_CMD_QRY_PERM : ewp_pkg::EWP_CMD_SET_PERM;
			else if (isRead)
				cmd = ewp_pkg::EWP_CMD_QRY_REV;
			else if (subCode == `EWP_SUBCODE_SET_REV)
				cmd = ewp_pkg::EWP_CMD_SET_REV;
			else if (subCode == `EWP_SUBCODE_CLR_REV)
				cmd = ewp_pkg::EWP_CMD_CLR_REV;
		end
	end

	// ========================================
	// Acknowledge decision
	// ========================================
	ewp_pkg::ewp_flags_t flags_q;
	ewp_pkg::ewp_flags_t flags_d;
	logic                ackDecide;

	always_comb
	begin
		ackDecide = 1'b0;
		unique case (cmd)
			ewp_pkg::EWP_CMD_NONE:
				ackDecide = 1'b0;
			// Array access is acknowledged whatever the protection
			ewp_pkg::EWP_CMD_ARRAY_RD,
			ewp_pkg::EWP_CMD_ARRAY_WR:
				ackDecide = 1'b1;
			ewp_pkg::EWP_CMD_QRY_PERM,
			ewp_pkg::EWP_CMD_SET_PERM,
			ewp_pkg::EWP_CMD_CLR_REV:
				ackDecide = ~flags_q.permanentProtectFlag;
			ewp_pkg::EWP_CMD_QRY_REV,
			ewp_pkg::EWP_CMD_SET_REV:
				ackDecide = ~flags_q.reversibleProtectFlag;
		endcase
	end

	// ========================================
	// Sequencer: drive ack through the ninth bit, then hold flag writes to the stop
	// ========================================
	ewp_pkg::ewp_state_t state_q;
	ewp_pkg::ewp_state_t state_d;
	ewp_pkg::ewp_cmd_t   cmdHeld_q;
	ewp_pkg::ewp_cmd_t   cmdHeld_d;
	logic                ackHeld_q;
	logic                ackHeld_d;
	logic                sdaOe_q;
	logic                sdaOe_d;
	logic                ackGiven_q;
	logic                ackGiven_d;
	logic                readEn_q;
	logic                readEn_d;

	always_comb
	begin
		state_d    = state_q;
		cmdHeld_d  = cmdHeld_q;
		ackHeld_d  = ackHeld_q;
		sdaOe_d    = sdaOe_q;
		ackGiven_d = 1'b0;
		readEn_d   = readEn_q;
		unique case (state_q)
			ewp_pkg::EWP_IDLE:
			begin
				if (addrByteValid)
				begin
					cmdHeld_d = cmd;
					ackHeld_d = ackDecide;
					readEn_d  = 1'b0;
					state_d   = ewp_pkg::EWP_ACK_WAIT;
				end
			end
			ewp_pkg::EWP_ACK_WAIT:
			begin
				if (serialClkFall)
				begin
					sdaOe_d    = ackHeld_q;
					ackGiven_d = ackHeld_q;
					state_d    = ackHeld_q ? ewp_pkg::EWP_ACK_HOLD : ewp_pkg::EWP_IDLE;
				end
			end
			ewp_pkg::EWP_ACK_HOLD:
			begin
				if (serialClkFall)
				begin
					sdaOe_d  = 1'b0;
					readEn_d = (cmdHeld_q == ewp_pkg::EWP_CMD_ARRAY_RD);
					// Query data is don't-care; the array path may shift anything
					unique case (cmdHeld_q)
						ewp_pkg::EWP_CMD_SET_PERM,
						ewp_pkg::EWP_CMD_SET_REV,
						ewp_pkg::EWP_CMD_CLR_REV:
							state_d = ewp_pkg::EWP_CMD_PEND;
						default:
							state_d = ewp_pkg::EWP_IDLE;
					endcase
				end
			end
			ewp_pkg::EWP_CMD_PEND:
			begin
				if (writeStop || addrByteValid)
					state_d = ewp_pkg::EWP_IDLE;
			end
			default:
				state_d = ewp_pkg::EWP_IDLE;
		endcase
		if (writeStop)
			readEn_d = 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			state_q    <= ewp_pkg::EWP_IDLE;
			cmdHeld_q  <= ewp_pkg::EWP_CMD_NONE;
			ackHeld_q  <= 1'b0;
			sdaOe_q    <= 1'b0;
			ackGiven_q <= 1'b0;
			readEn_q   <= 1'b0;
		end
		else
		begin
			state_q    <= state_d;
			cmdHeld_q  <= cmdHeld_d;
			ackHeld_q  <= ackHeld_d;
			sdaOe_q    <= sdaOe_d;
			ackGiven_q <= ackGiven_d;
			readEn_q   <= readEn_d;
		end
	end

	// ========================================
	// Protect flags, committed at the stop that opens the write cycle
	// ========================================
	logic flagCommit;
	logic nvUpdate_q;
	logic nvUpdate_d;

	assign flagCommit = (state_q == ewp_pkg::EWP_CMD_PEND) & writeStop;

	always_comb
	begin
		flags_d    = flags_q;
		nvUpdate_d = 1'b0;
		if (!resetn)
			flags_d = nvFlagsIn; // Stored state survives power loss
		else if (flagCommit && !protectHigh)
		begin
			nvUpdate_d = 1'b1;
			unique case (cmdHeld_q)
				ewp_pkg::EWP_CMD_SET_PERM:
					flags_d.permanentProtectFlag = 1'b1;
				ewp_pkg::EWP_CMD_SET_REV:
					flags_d.reversibleProtectFlag = 1'b1;
				ewp_pkg::EWP_CMD_CLR_REV:
					flags_d.reversibleProtectFlag = 1'b0;
				default:
					nvUpdate_d = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		flags_q    <= flags_d;
		nvUpdate_q <= nvUpdate_d;
	end

	// ========================================
	// Array store gating
	// ========================================
	logic                  store_q;
	logic                  store_d;
	logic [ADDR_WIDTH-1:0] storeAddr_q;
	logic [ADDR_WIDTH-1:0] storeAddr_d;
	logic                  storeAllowed;
	logic                  anyFlag;

	assign anyFlag = flags_q.permanentProtectFlag | flags_q.reversibleProtectFlag;

	always_comb
	begin
		if (protectHigh)
			storeAllowed = 1'b0;
		else if (anyFlag)
			storeAllowed = (dataAddr > `EWP_LOWER_HALF_TOP);
		else
			storeAllowed = 1'b1;
		// A refused byte is acked upstream all the same; timing stays unchanged
		store_d     = dataByteValid & storeAllowed &
			(cmdHeld_q == ewp_pkg::EWP_CMD_ARRAY_WR);
		storeAddr_d = dataByteValid ? dataAddr : storeAddr_q;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			store_q     <= 1'b0;
			storeAddr_q <= '0;
		end
		else
		begin
			store_q     <= store_d;
			storeAddr_q <= storeAddr_d;
		end
	end

	// ========================================
	// Outputs
	// ========================================
	logic sdaOut_q;

	always_ff @(posedge clk)
	begin
		sdaOut_q <= 1'b0;
	end

	assign sdaOut         = sdaOut_q;
	assign sdaOe          = sdaOe_q;
	assign ackGiven       = ackGiven_q;
	assign arrayReadEn    = readEn_q;
	assign arrayStore     = store_q;
	assign arrayStoreAddr = storeAddr_q;
	assign flags          = flags_q;
	assign nvFlagsUpdate  = nvUpdate_q;

endmodule // ewp_decision

`default_nettype wire

// [logic/ewp_decision_defs.svh]
`ifndef EWP_DECISION_DEFS_SVH
`define EWP_DECISION_DEFS_SVH

`define EWP_PREAMBLE_ARRAY 4'hA
`define EWP_PREAMBLE_FLAG 4'h6
`define EWP_PREAMBLE_MSB 7
`define EWP_PREAMBLE_LSB 4
`define EWP_RW_BIT 0
`define EWP_SUBCODE_MSB 3
`define EWP_SUBCODE_LSB 1
`define EWP_SUBCODE_SET_REV 3'h1
`define EWP_SUBCODE_CLR_REV 3'h3
`define EWP_LOWER_HALF_TOP 8'h7F
`define EWP_FLAG_RESET 1'b0
`define EWP_SYNC_RESET 1'b0

`endif

// [logic/ewp_pkg.sv]
package ewp_pkg;

	typedef enum logic [3:0] {
		EWP_IDLE     = 4'b0001,
		EWP_ACK_WAIT = 4'b0010,
		EWP_ACK_HOLD = 4'b0100,
		EWP_CMD_PEND = 4'b1000
	} ewp_state_t;

	typedef enum logic [2:0] {
		EWP_CMD_NONE      = 3'h0,
		EWP_CMD_ARRAY_RD  = 3'h1,
		EWP_CMD_ARRAY_WR  = 3'h2,
		EWP_CMD_QRY_PERM  = 3'h3,
		EWP_CMD_SET_PERM  = 3'h4,
		EWP_CMD_QRY_REV   = 3'h5,
		EWP_CMD_SET_REV   = 3'h6,
		EWP_CMD_CLR_REV   = 3'h7
	} ewp_cmd_t;

	// Pins that arrive from outside the clock domain
	typedef struct packed {
		logic serialClk;
		logic protectPin;
		logic elevatedPinLevel;
	} ewp_pins_t;

	typedef struct packed {
		logic permanentProtectFlag;
		logic reversibleProtectFlag;
	} ewp_flags_t;

endpackage

// [logic/ewp_sync3.sv]
`timescale 1ns/100ps
`default_nettype none
`include "ewp_decision_defs.svh"

module ewp_sync3 #(
	parameter int WIDTH = 3
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] async,
	output var  logic [WIDTH-1:0] synced
);

	// ========================================
	// Three stages; accepted once stages two and three agree
	// ========================================
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] out_q;
	logic [WIDTH-1:0] out_d;

	// Elaboration check: an empty bus has nothing to synchronise
	if (WIDTH < 1)
	begin : g_width_check
		$error("ewp_sync3: WIDTH must be at least 1");
	end

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			always_comb
			begin
				out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
			end
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			s1_q  <= {WIDTH{`EWP_SYNC_RESET}};
			s2_q  <= {WIDTH{`EWP_SYNC_RESET}};
			s3_q  <= {WIDTH{`EWP_SYNC_RESET}};
			out_q <= {WIDTH{`EWP_SYNC_RESET}};
		end
		else
		begin
			s1_q  <= async;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			out_q <= out_d;
		end
	end

	assign synced = out_q;

endmodule // ewp_sync3

`default_nettype wire

// [verif/ewp_decision_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module ewp_decision_assertions #(
	parameter int ADDR_WIDTH = 8
) (
	input wire logic                  clk,
	input wire logic                  resetn,
	input wire ewp_pkg::ewp_pins_t    pins,
	input wire logic                  addrByteValid,
	input wire logic [7:0]            addrByte,
	input wire logic                  dataByteValid,
	input wire logic [ADDR_WIDTH-1:0] dataAddr,
	input wire logic                  writeStop,
	input wire logic                  sdaOut,
	input wire logic                  sdaOe,
	input wire logic                  ackGiven,
	input wire logic                  arrayStore,
	input wire logic [ADDR_WIDTH-1:0] arrayStoreAddr,
	input wire ewp_pkg::ewp_flags_t   flags,
	input wire logic                  nvFlagsUpdate
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// ================
	// Sequences
	sequence ackHold;
		sdaOe[*4] ##[1:12] !sdaOe;
	endsequence
	sequence permCmd;
		addrByteValid && addrByte[7:4] == 4'h6 && !pins.elevatedPinLevel;
	endsequence
	// ================
	// Checks
	chk_ack_drive: assert property (ackGiven |-> sdaOe && !sdaOut)
		else $error("ack without low drive");
	chk_ack_window: assert property ($rose(sdaOe) |-> ackHold)
		else $error("ack drive length wrong");
	chk_perm_noack: assert property (permCmd ##0 flags.permanentProtectFlag
		|-> not (##[1:30] ackGiven))
		else $error("ack with permanent flag set");
	chk_store_upper: assert property (arrayStore && |flags |-> arrayStoreAddr[ADDR_WIDTH-1])
		else $error("store into lower half");
	chk_store_pin: assert property (pins.protectPin && $past(pins.protectPin, 8)
		|-> !arrayStore)
		else $error("store while pin high");
	chk_store_cause: assert property (arrayStore
		|-> $past(dataByteValid) && arrayStoreAddr == $past(dataAddr))
		else $error("store without data byte");
	chk_perm_sticky: assert property ($past(flags.permanentProtectFlag)
		|-> flags.permanentProtectFlag)
		else $error("permanent flag cleared");
	chk_flag_commit: assert property ($changed(flags) |-> $past(writeStop) && nvFlagsUpdate)
		else $error("flag change without stop");
endmodule // ewp_decision_assertions

bind ewp_decision ewp_decision_assertions #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (
	.clk, .resetn, .pins, .addrByteValid, .addrByte, .dataByteValid, .dataAddr,
	.writeStop, .sdaOut, .sdaOe, .ackGiven, .arrayStore, .arrayStoreAddr,
	.flags, .nvFlagsUpdate
);
`default_nettype wire

// [verif/ewp_master_model.sv]
`timescale 1ns/100ps
`default_nettype none
module ewp_master_model (
	input  wire logic              start,
	input  wire ewp_pkg::ewp_cmd_t cmd,
	output var  logic              serialClk,
	output var  logic              elevatedPinLevel,
	output var  logic [7:0]        addrByte
);
	// Clock idles high under the pull-up and runs only within a frame
	// Edges land on a clk edge; non-blocking keeps the sampling order fixed
	initial
	begin
		serialClk = 1'b1;
		forever
		begin
			@(posedge start);
			repeat (2)
			begin
				#160 serialClk <= 1'b0;
				#160 serialClk <= 1'b1;
			end
		end
	end
	always_comb
	begin
		elevatedPinLevel = 1'b0;
		case (cmd)
			ewp_pkg::EWP_CMD_ARRAY_RD: addrByte = 8'hA1;
			ewp_pkg::EWP_CMD_ARRAY_WR: addrByte = 8'hA0;
			ewp_pkg::EWP_CMD_QRY_PERM: addrByte = 8'h61;
			ewp_pkg::EWP_CMD_SET_PERM: addrByte = 8'h60;
			ewp_pkg::EWP_CMD_QRY_REV: addrByte = 8'h63;
			ewp_pkg::EWP_CMD_SET_REV: addrByte = 8'h62;
			default: addrByte = 8'h66;
		endcase
		if (addrByte[7:4] == 4'h6 && addrByte[3:1] != 3'h0)
			elevatedPinLevel = 1'b1;
	end
endmodule // ewp_master_model
`default_nettype wire

// [verif/ewp_decision_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb;
	localparam ewp_pkg::ewp_cmd_t RD = ewp_pkg::EWP_CMD_ARRAY_RD;
	localparam ewp_pkg::ewp_cmd_t QP = ewp_pkg::EWP_CMD_QRY_PERM;
	localparam ewp_pkg::ewp_cmd_t SP = ewp_pkg::EWP_CMD_SET_PERM;
	localparam ewp_pkg::ewp_cmd_t QR = ewp_pkg::EWP_CMD_QRY_REV;
	localparam ewp_pkg::ewp_cmd_t SR = ewp_pkg::EWP_CMD_SET_REV;
	localparam ewp_pkg::ewp_cmd_t CR = ewp_pkg::EWP_CMD_CLR_REV;
	logic                clk;
	logic                resetn;
	logic                protectPin;
	logic                start;
	logic                addrByteValid;
	logic                dataByteValid;
	logic [7:0]          dataAddr;
	logic                writeStop;
	ewp_pkg::ewp_flags_t nvFlagsIn;
	ewp_pkg::ewp_cmd_t   cmd;
	logic                serialClk;
	logic                elevatedPinLevel;
	logic [7:0]          addrByte;
	logic                sdaOe;
	logic                ackGiven;
	logic                arrayReadEn;
	logic                arrayStore;
	logic [7:0]          arrayStoreAddr;
	ewp_pkg::ewp_flags_t flags;
	logic                nvFlagsUpdate;
	int                  n_mismatch;
	int                  cmp_count;

	ewp_master_model master_u (.start, .cmd, .serialClk, .elevatedPinLevel, .addrByte);
	ewp_decision dut_u (
		.clk, .resetn,
		.pins(ewp_pkg::ewp_pins_t'({serialClk, protectPin, elevatedPinLevel})),
		.addrByteValid, .addrByte, .dataByteValid, .dataAddr, .writeStop, .nvFlagsIn,
		.sdaOut(), .sdaOe, .ackGiven, .arrayReadEn, .arrayStore, .arrayStoreAddr,
		.flags, .nvFlagsUpdate
	);

	// ================
	// Helpers
	task automatic check(input logic ok, input string msg);
		cmp_count++;
		if (ok !== 1'b1)
		begin
			n_mismatch++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask
	task automatic send(input ewp_pkg::ewp_cmd_t c, input logic expAck);
		logic got;
		got = 1'b0;
		@(posedge clk);
		cmd <= c;
		// Elevated level must pass the pin synchroniser first
		repeat (6) @(posedge clk);
		addrByteValid <= 1'b1;
		start <= 1'b1;
		@(posedge clk);
		addrByteValid <= 1'b0;
		start <= 1'b0;
		repeat (40) @(negedge clk) got |= ackGiven;
		check(got === expAck, "ack");
	endtask
	task automatic stop(input ewp_pkg::ewp_flags_t f, input logic upd);
		@(posedge clk);
		writeStop <= 1'b1;
		@(posedge clk);
		writeStop <= 1'b0;
		@(negedge clk);
		check(flags === f && nvFlagsUpdate === upd, "flags");
	endtask
	task automatic op(input ewp_pkg::ewp_cmd_t c, input logic a, input logic [1:0] f,
		input logic upd);
		send(c, a);
		stop(f, upd);
	endtask
	task automatic write(input logic [7:0] a, input logic exp, input logic [1:0] f);
		send(ewp_pkg::EWP_CMD_ARRAY_WR, 1'b1);
		@(posedge clk);
		dataByteValid <= 1'b1;
		dataAddr <= a;
		@(posedge clk);
		dataByteValid <= 1'b0;
		@(negedge clk);
		check(arrayStore === exp && (!exp || arrayStoreAddr === a), "store");
		stop(f, 1'b0);
	endtask
	task automatic setPin(input logic v);
		@(posedge clk);
		protectPin <= v;
		repeat (8) @(posedge clk);
	endtask

	// ================
	// Scenarios
	task automatic s_open();
		send(RD, 1'b1);
		check(arrayReadEn === 1'b1, "read enable");
		stop(2'b00, 1'b0);
		write(8'h00, 1'b1, 2'b00);
		op(QP, 1'b1, 2'b00, 1'b0);
		op(QR, 1'b1, 2'b00, 1'b0);
	endtask
	task automatic s_pin_high();
		setPin(1'b1);
		op(RD, 1'b1, 2'b00, 1'b0);
		write(8'hF0, 1'b0, 2'b00);
		op(SR, 1'b1, 2'b00, 1'b0);
		op(SP, 1'b1, 2'b00, 1'b0);
		op(CR, 1'b1, 2'b00, 1'b0);
		setPin(1'b0);
	endtask
	task automatic s_rev();
		op(SR, 1'b1, 2'b01, 1'b1);
		op(QR, 1'b0, 2'b01, 1'b0);
		op(SR, 1'b0, 2'b01, 1'b0);
		write(8'h7F, 1'b0, 2'b01);
		write(8'h80, 1'b1, 2'b01);
		op(CR, 1'b1, 2'b00, 1'b1);
	endtask
	task automatic s_perm();
		op(SP, 1'b1, 2'b10, 1'b1);
		write(8'h7F, 1'b0, 2'b10);
		for (int i = 0; i < 2; i++)
		begin
			setPin(i[0]);
			op(QP, 1'b0, 2'b10, 1'b0);
			op(SP, 1'b0, 2'b10, 1'b0);
			op(CR, 1'b0, 2'b10, 1'b0);
		end
		setPin(1'b0);
	endtask
	task automatic s_nv();
		@(posedge clk);
		nvFlagsIn <= 2'b11;
		resetn <= 1'b0;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		@(negedge clk);
		check(flags === 2'b11, "nv load");
		write(8'hC0, 1'b1, 2'b11);
	endtask
	task automatic wrap_up();
		$display("Mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial
	begin
		{resetn, protectPin, start, addrByteValid, dataByteValid, writeStop} = '0;
		dataAddr = 8'h00;
		nvFlagsIn = 2'b00;
		cmd = RD;
		n_mismatch = 0;
		cmp_count = 0;
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		s_open();
		s_pin_high();
		s_rev();
		s_perm();
		s_nv();
		wrap_up();
	end
endmodule // tb
`default_nettype wire
